// ### core/mpt_consts.vh
// Register map, field positions and reset values for the multi-PWM trip block
`ifndef MPT_CONSTS_VH
`define MPT_CONSTS_VH
// Printed offsets are not multiples of four: index, byte address = 4 * index
`define MPT_IDX_ENABLE 12'h079
`define MPT_IDX_GATING 12'h07a
`define MPT_IDX_TRIP 12'h07b
`define MPT_IDX_IRQ_STAT 12'h07c
`define MPT_IDX_IRQ_EN 12'h07d
`define MPT_IDX_IRQ_CLR 12'h07e
`define MPT_IDX_OUT_PORT 12'h07f
// Enable register fields
`define MPT_EN_PAIR 7
`define MPT_EN_TRIP 6
`define MPT_EN_MIRROR 5
`define MPT_EN_GEN_HI 4
`define MPT_EN_GEN_LO 1
`define MPT_EN_MULTI 0
// Gating register fields
`define MPT_GT_INV_HI 7
`define MPT_GT_INV_LO 6
`define MPT_GT_TRUE_HI 5
`define MPT_GT_TRUE_LO 4
`define MPT_GT_DT_HI 3
`define MPT_GT_DT_LO 0
`define MPT_GATE_AND 2'h1
`define MPT_GATE_OR 2'h2
// Trip register fields
`define MPT_TR_IN_HI 7
`define MPT_TR_IN_LO 4
`define MPT_TR_DRIVE 3
`define MPT_TR_LVL_TRUE 2
`define MPT_TR_LVL_INV 1
`define MPT_TR_FLAG 0
// Interrupt status bits
`define MPT_IRQ_TRIP 0
`define MPT_IRQ_CLEAR 1
`define MPT_RST_BYTE 8'h00
`endif

// ### core/mpt_dead_time.v
// Dead-time delay for one complementary output pair
`timescale 1ns/1ps
`default_nettype none
module mpt_dead_time #(
  parameter CW = 4
) (
  input wire clock,
  input wire rst,
  input wire rawIn,
  input wire [CW-1:0] delayCount,
  output reg trueOut,
  output reg invOut
);
  reg [CW-1:0] cnt_r;
  reg level_r;

  // Rising edges of either side wait delayCount cycles after the partner falls
  always @(posedge clock) begin
    if (rst) begin
      cnt_r <= {CW{1'b0}};
      level_r <= 1'b0;
      trueOut <= 1'b0;
      invOut <= 1'b1;
    end else if (rawIn != level_r) begin
      level_r <= rawIn;
      trueOut <= 1'b0;
      invOut <= 1'b0;
      cnt_r <= delayCount;
      if (delayCount == {CW{1'b0}}) begin
        trueOut <= rawIn;
        invOut <= ~rawIn;
      end
    end else if (cnt_r != {CW{1'b0}}) begin
      cnt_r <= cnt_r - 1'b1;
      if (cnt_r == {{(CW-1){1'b0}}, 1'b1}) begin
        trueOut <= level_r;
        invOut <= ~level_r;
      end
    end else begin
      trueOut <= level_r;
      invOut <= ~level_r;
    end
  end
endmodule
`default_nettype wire

// ### core/mpt_trip_control.v
// Multi-PWM trip, enable, gating and dead-time control with APB registers
// Function
// (R01) Enabled trip input event forces enabled outputs
// (R02) Any combination of inputs; one trips
// (R03) Per-input enable bit in trip register
// (R04) Trip sets detected flag to one
// (R05) Outputs held until software clears flag
// (R06) Global safe state per true/inverted group
// (R07) Enable bit 6 turns trip feature on
// (R08) Bit 7 enables inverted outputs too
// (R09) Generator, mirror and multi-output enable bits
// (R10) Bits 7:6 gate inverted outputs AND/OR
// (R11) Bits 5:4 gate true outputs AND/OR
// (R12) Dead time N cycles, 0 to 15
// (R13) Control registers reset zero, read/write
// (R14) Gating combines with port output bits
// (R15) Trip bits 7:4 enable inputs 3:0
// (R16) Bit 3 float, else bits 2/1 levels
// (R17) Dead time global to all pairs
// (R18) Synchronised trips force from next cycle; code sets the flag next cycle and forces the outputs the cycle after
// (R19) Software checks load before clearing flag
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "mpt_consts.vh"
module mpt_trip_control #(
  parameter NCH = 4,
  parameter DTW = 4
) (
  input wire clock,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [NCH-1:0] genRaw,
  input wire [NCH-1:0] tripIn,
  output reg [NCH-1:0] pwmTrueOut,
  output reg [NCH-1:0] pwmTrueOe_n,
  output reg [NCH-1:0] pwmInvOut,
  output reg [NCH-1:0] pwmInvOe_n,
  output wire irq
);
  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  reg [7:0] enableCtl_r;
  reg [7:0] gatingCtl_r;
  reg [7:4] tripInEn_r;
  reg [3:1] tripCfg_r;
  reg tripFlag_r;
  reg [1:0] irqStat_r;
  reg [1:0] irqEn_r;
  reg [7:0] outPortT_r;
  reg [NCH-1:0] sync1_r;
  reg [NCH-1:0] sync2_r;
  wire [11:0] regIdx = paddr[13:2];
  wire wrEn = psel & penable & pwrite;
  wire rdEn = psel & penable & ~pwrite;
  wire hitEnable = regIdx == `MPT_IDX_ENABLE;
  wire hitGating = regIdx == `MPT_IDX_GATING;
  wire hitTrip = regIdx == `MPT_IDX_TRIP;
  wire hitStat = regIdx == `MPT_IDX_IRQ_STAT;
  wire hitIrqEn = regIdx == `MPT_IDX_IRQ_EN;
  wire hitClr = regIdx == `MPT_IDX_IRQ_CLR;
  wire hitPort = regIdx == `MPT_IDX_OUT_PORT;
  wire mapped = (hitEnable | hitGating | hitTrip | hitStat | hitIrqEn | hitClr | hitPort)
    & (paddr[1:0] == 2'h0) & (paddr[31:14] == 18'h00000);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // ----------------------------------------------------------------
  // Trip detection
  // ----------------------------------------------------------------
  // Trip inputs cross from pins through two flip-flops
  always @(posedge clock) begin
    if (rst) begin
      sync1_r <= {NCH{1'b0}};
      sync2_r <= {NCH{1'b0}};
    end else begin
      sync1_r <= tripIn;
      sync2_r <= sync1_r;
    end
  end
  wire tripFeature = enableCtl_r[`MPT_EN_TRIP]; // see (R07)
  wire tripEvent = tripFeature & (|(sync2_r & tripInEn_r)); // see (R01) see (R02) see (R03) see (R15) see (R18)
  wire flagClearWr = wrEn & mapped & hitTrip & ~pwdata[`MPT_TR_FLAG];
  wire flagFall = tripFlag_r & flagClearWr & ~tripEvent;

  always @(posedge clock) begin
    if (rst) begin
      enableCtl_r <= `MPT_RST_BYTE;
      gatingCtl_r <= `MPT_RST_BYTE;
      tripInEn_r <= 4'h0;
      tripCfg_r <= 3'h0;
      tripFlag_r <= 1'b0;
      irqStat_r <= 2'h0;
      irqEn_r <= 2'h0;
      outPortT_r <= `MPT_RST_BYTE;
    end else begin
      if (wrEn & mapped & hitEnable) begin
        enableCtl_r <= pwdata[7:0]; // see (R13)
      end
      if (wrEn & mapped & hitGating) begin
        gatingCtl_r <= pwdata[7:0]; // see (R13)
      end
      if (wrEn & mapped & hitTrip) begin
        tripInEn_r <= pwdata[`MPT_TR_IN_HI:`MPT_TR_IN_LO];
        tripCfg_r <= pwdata[`MPT_TR_DRIVE:`MPT_TR_LVL_INV];
      end
      if (wrEn & mapped & hitIrqEn) begin
        irqEn_r <= pwdata[1:0];
      end
      if (wrEn & mapped & hitPort) begin
        outPortT_r <= pwdata[7:0];
      end
      // Set wins over a clearing write in the same cycle
      if (tripEvent) begin
        tripFlag_r <= 1'b1; // see (R04)
      end else if (flagClearWr) begin
        tripFlag_r <= 1'b0; // see (R05)
      end
      irqStat_r[`MPT_IRQ_TRIP] <= (irqStat_r[`MPT_IRQ_TRIP]
        & ~(wrEn & mapped & hitClr & pwdata[`MPT_IRQ_TRIP]))
        | (tripEvent & ~tripFlag_r);
      irqStat_r[`MPT_IRQ_CLEAR] <= (irqStat_r[`MPT_IRQ_CLEAR]
        & ~(wrEn & mapped & hitClr & pwdata[`MPT_IRQ_CLEAR])) | flagFall;
    end
  end
  assign irq = |(irqStat_r & irqEn_r);

  always @* begin
    prdata = 32'h00000000;
    if (rdEn & mapped) begin
      if (hitEnable) begin
        prdata[7:0] = enableCtl_r;
      end else if (hitGating) begin
        prdata[7:0] = gatingCtl_r;
      end else if (hitTrip) begin
        prdata[7:0] = {tripInEn_r, tripCfg_r, tripFlag_r};
      end else if (hitStat) begin
        prdata[1:0] = irqStat_r;
      end else if (hitIrqEn) begin
        prdata[1:0] = irqEn_r;
      end else if (hitPort) begin
        prdata[7:0] = outPortT_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output path
  // ----------------------------------------------------------------
  wire multiOn = enableCtl_r[`MPT_EN_MULTI]; // see (R09)
  wire mirrorOn = enableCtl_r[`MPT_EN_MIRROR]; // see (R09)
  wire pairOn = enableCtl_r[`MPT_EN_PAIR]; // see (R08)
  wire [NCH-1:0] genOn = enableCtl_r[`MPT_EN_GEN_HI:`MPT_EN_GEN_LO]; // see (R09)
  wire [1:0] invGate = gatingCtl_r[`MPT_GT_INV_HI:`MPT_GT_INV_LO];
  wire [1:0] trueGate = gatingCtl_r[`MPT_GT_TRUE_HI:`MPT_GT_TRUE_LO];
  wire [DTW-1:0] deadTime = gatingCtl_r[`MPT_GT_DT_HI:`MPT_GT_DT_LO]; // see (R17)
  wire floatSel = ~tripCfg_r[`MPT_TR_DRIVE];
  wire lvlTrue = ~tripCfg_r[`MPT_TR_LVL_TRUE];
  wire lvlInv = ~tripCfg_r[`MPT_TR_LVL_INV];
  wire tripActive = tripFeature & tripFlag_r;

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : gCh
      wire srcRaw = mirrorOn ? genRaw[0] : genRaw[g];
      wire dtTrue;
      wire dtInv;
      reg gTrue;
      reg gInv;
      mpt_dead_time #(.CW(DTW)) uDead (
        .clock(clock),
        .rst(rst),
        .rawIn(srcRaw),
        .delayCount(deadTime), // see (R12)
        .trueOut(dtTrue),
        .invOut(dtInv)
      );
      always @* begin
        gTrue = dtTrue;
        gInv = dtInv;
        if (trueGate == `MPT_GATE_AND) begin
          gTrue = dtTrue & outPortT_r[g]; // see (R11) see (R14)
        end else if (trueGate == `MPT_GATE_OR) begin
          gTrue = dtTrue | outPortT_r[g]; // see (R11) see (R14)
        end
        if (invGate == `MPT_GATE_AND) begin
          gInv = dtInv & outPortT_r[g + NCH]; // see (R10) see (R14)
        end else if (invGate == `MPT_GATE_OR) begin
          gInv = dtInv | outPortT_r[g + NCH]; // see (R10) see (R14)
        end
      end
      wire chOn = multiOn & genOn[g];
      always @(posedge clock) begin
        if (rst) begin
          pwmTrueOut[g] <= 1'b0;
          pwmTrueOe_n[g] <= 1'b1;
          pwmInvOut[g] <= 1'b0;
          pwmInvOe_n[g] <= 1'b1;
        end else if (tripActive & chOn) begin
          pwmTrueOut[g] <= lvlTrue; // see (R06) see (R16) see (R01)
          pwmTrueOe_n[g] <= floatSel;
          pwmInvOut[g] <= lvlInv;
          pwmInvOe_n[g] <= floatSel | ~pairOn;
        end else begin
          pwmTrueOut[g] <= gTrue;
          pwmTrueOe_n[g] <= ~chOn;
          pwmInvOut[g] <= gInv;
          pwmInvOe_n[g] <= ~(chOn & pairOn); // see (R08)
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ### verification/mpt_checker.sv
// Port assertions for the multi-PWM trip block
`timescale 1ns/1ps
`default_nettype none
module mpt_checker #(parameter NCH = 4) (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NCH-1:0] tripIn,
  input wire logic [NCH-1:0] pwmTrueOut,
  input wire logic [NCH-1:0] pwmTrueOe_n,
  input wire logic [NCH-1:0] pwmInvOe_n,
  input wire logic irq
);
  logic [7:0] enR, trR;
  logic arm;
  logic [3:0] on;
  assign arm = enR[6] && |(trR[7:4] & tripIn);
  assign on = enR[0] ? enR[4:1] : 4'h0;
  always_ff @(posedge clock) begin
    if (rst)
      {enR, trR} <= 16'h0;
    else if (psel && penable && pwrite && paddr == 32'h1e4)
      enR <= pwdata[7:0];
    else if (psel && penable && pwrite && paddr == 32'h1ec)
      trR <= pwdata[7:0];
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence held_s(logic d);
    (arm && trR[3] == d) [*4];
  endsequence
  ready_on_a: assert property (pready) else $error("pready low");
  bad_addr_a: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("no refusal");
  read_back_a: assert property (psel && penable && !pwrite && paddr == 32'h1e4
    |-> prdata == {24'h0, enR}) else $error("bad readback");
  trip_float_a: assert property (held_s(1'b0) |=> &pwmTrueOe_n && &pwmInvOe_n)
    else $error("trip not floated");
  trip_drive_a: assert property (held_s(1'b1) |=> (pwmTrueOe_n & on) == 4'h0
    && (pwmTrueOut & on) == ({4{!trR[2]}} & on)) else $error("trip level wrong");
  reset_idle_a: assert property ($fell(rst) |-> &pwmTrueOe_n && !irq)
    else $error("reset state");
  multi_off_a: assert property (!enR[0] [*3] |-> &pwmTrueOe_n && &pwmInvOe_n)
    else $error("drives while off");
  pair_off_a: assert property ((enR[0] && !enR[7]) [*3] |-> &pwmInvOe_n)
    else $error("inverted drives");
endmodule
`default_nettype wire

// ### verification/mpt_power_stage.sv
// Power stage model: gate pins and load fault lines
`timescale 1ns/1ps
`default_nettype none
module mpt_power_stage (
  input wire logic clock,
  input wire logic [3:0] tOut,
  input wire logic [3:0] tOe_n,
  input wire logic [3:0] iOut,
  input wire logic [3:0] iOe_n,
  input wire logic [3:0] cmd,
  output logic [3:0] fault,
  output logic [3:0] tPin,
  output logic [3:0] iPin,
  output logic loadOk
);
  // Released gate inputs pulled low
  assign tPin = tOut & ~tOe_n;
  assign iPin = iOut & ~iOe_n;
  always_ff @(posedge clock) fault <= cmd;
  assign loadOk = fault == 4'h0;
endmodule
`default_nettype wire

// ### verification/multi_pwm_trip_and_control_test.sv
// Self-checking bench for the multi-PWM trip block
`timescale 1ns/1ps
`default_nettype none
module multi_pwm_trip_and_control_test;
  localparam logic [31:0] EN = 32'h1e4, GT = 32'h1e8, TR = 32'h1ec, IST = 32'h1f0;
  localparam logic [31:0] IEN = 32'h1f4, ICL = 32'h1f8, PRT = 32'h1fc;
  logic clock, rst, psel, penable, pwrite, err;
  logic [31:0] paddr, pwdata, q;
  logic [3:0] genRaw, cmd;
  logic [7:0] p, m;
  wire [31:0] prdata;
  wire pready, pslverr, irq, ok;
  wire [3:0] tripIn, pwmTrueOut, pwmTrueOe_n, pwmInvOut, pwmInvOe_n, tPin, iPin;
  int bad_count, check_count, j, k, n;
  int regs[int];
  mpt_trip_control i_mpt_trip_control (.*);
  mpt_power_stage i_mpt_power_stage (.clock(clock), .tOut(pwmTrueOut), .tOe_n(pwmTrueOe_n),
    .iOut(pwmInvOut), .iOe_n(pwmInvOe_n), .cmd(cmd), .fault(tripIn), .tPin(tPin),
    .iPin(iPin), .loadOk(ok));
  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string w);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (wr) regs[a] = d[7:0];
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q, e, "read");
  endtask
  function automatic logic [3:0] gate(input int c, input logic [3:0] v, input logic [3:0] r);
    return c == 1 ? v & r : c == 2 ? v | r : v;
  endfunction
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    close_out;
  end
  initial begin
    k = $urandom(32'h859b);
    {psel, penable, pwrite, paddr, pwdata, genRaw, cmd} = '0;
    rst = 1'b1;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    for (k = 0; k < 3; k++) rd(EN + 4 * k, 0);
    rd(32'h200, 0);
    chk(err, 1, "slverr");
    for (k = 0; k < 8; k++) begin
      apb(1'b1, k[0] ? GT : EN, $urandom);
      rd(k[0] ? GT : EN, regs[k[0] ? GT : EN]);
    end
    $display("done registers");
    apb(1'b1, EN, 32'h9f);
    for (k = 0; k < 3; k++) begin
      n = k == 2 ? $urandom_range(14, 1) : 15 * k;
      apb(1'b1, GT, n);
      repeat (20) @(posedge clock);
      genRaw <= 4'hf;
      do @(negedge clock); while (pwmInvOut[0] !== 1'b0);
      for (j = 0; pwmTrueOut[0] !== 1'b1 && j < 30; j++) @(negedge clock);
      chk(j, n, "dead");
      chk(32'(pwmTrueOut), 32'hf, "pairs");
      @(posedge clock);
      genRaw <= 4'h0;
    end
    $display("done dead time");
    for (k = 0; k < 4; k++) begin
      p = $urandom;
      m = $urandom;
      apb(1'b1, PRT, p);
      apb(1'b1, GT, k * 32'h50);
      genRaw <= m[3:0];
      repeat (20) @(negedge clock);
      chk(32'(pwmTrueOut), 32'(gate(k, m[3:0], p[3:0])), "tgate");
      chk(32'(pwmInvOut), 32'(gate(k, ~m[3:0], p[7:4])), "igate");
    end
    apb(1'b1, EN, 32'hbf);
    genRaw <= 4'h1;
    repeat (20) @(negedge clock);
    chk(32'(pwmTrueOut), 32'hf, "mirror");
    $display("done gating");
    apb(1'b1, EN, 32'hdf);
    apb(1'b1, IEN, 32'h3);
    for (k = 0; k < 4; k++) begin
      m = {4'h1 << k, k != 0, k[1:0], 1'b0};
      apb(1'b1, TR, m);
      cmd <= 4'h1 << ((k + 1) % 4);
      repeat (8) @(posedge clock);
      rd(TR, m);
      cmd <= 4'h1 << k;
      repeat (8) @(posedge clock);
      cmd <= 4'h0;
      repeat (8) @(negedge clock);
      chk(32'(pwmTrueOe_n), m[3] ? 0 : 32'hf, "toe");
      chk(32'(tPin), m[3] && !m[2] ? 32'hf : 0, "tpin");
      chk(32'(iPin), m[3] && !m[1] ? 32'hf : 0, "ipin");
      chk(irq, 1, "irq");
      rd(TR, m | 8'h1);
      if (ok) apb(1'b1, TR, m);
      repeat (4) @(negedge clock);
      chk(32'(pwmInvOe_n), 0, "free");
      rd(IST, 3);
      apb(1'b1, IEN, 0);
      @(negedge clock);
      chk(irq, 0, "mask");
      apb(1'b1, ICL, 3);
      apb(1'b1, IEN, 3);
      @(negedge clock);
      chk(irq, 0, "clear");
    end
    apb(1'b1, EN, 32'h9f);
    apb(1'b1, TR, 32'h10);
    cmd <= 4'h1;
    repeat (8) @(posedge clock);
    cmd <= 4'h0;
    repeat (4) @(negedge clock);
    chk(32'(pwmTrueOe_n), 0, "trip off");
    rd(TR, 32'h10);
    $display("done trip");
    close_out;
  end
endmodule
bind mpt_trip_control mpt_checker #(.NCH(NCH)) i_mpt_checker (.*);
`default_nettype wire
